// [fpa_pkg.sv]
// Package for the fan duty arbiter: register map, field layout, reset values,
// step codes and shared record types.
// Assumes a 32-bit AXI4-Lite register bus and one 250 MHz clock.
`default_nettype none
package fpa_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte addresses
   localparam logic [7:0] FPA_CTRL_ADDR     = 8'h00; // Force bit, alt map, lowfreq
   localparam logic [7:0] FPA_MANUAL_ADDR   = 8'h04; // Manual enables and codes
   localparam logic [7:0] FPA_BIND_ADDR     = 8'h08; // Ramp bindings
   localparam logic [7:0] FPA_RAMP_ADDR     = 8'h0c; // Ramp interval in ms
   localparam logic [7:0] FPA_SPIN_ADDR     = 8'h10; // Spin-up code and time
   localparam logic [7:0] FPA_STATUS_ADDR   = 8'h14; // Final codes and ramp state

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int FPA_CTRL_FORCE_BIT = 0;
   localparam int FPA_CTRL_ALT0_BIT  = 1;
   localparam int FPA_CTRL_ALT1_BIT  = 2;
   localparam int FPA_CTRL_LOWF0_BIT = 3;
   localparam int FPA_CTRL_LOWF1_BIT = 4;

   // Reset values
   localparam logic [31:0] FPA_CTRL_RST   = 32'h0000_0000;
   localparam logic [31:0] FPA_MANUAL_RST = 32'h0000_0000;
   localparam logic [31:0] FPA_BIND_RST   = 32'h0000_0000;
   localparam logic [7:0]  FPA_RAMP_RST   = 8'h01;
   localparam logic [15:0] FPA_SPIN_RST   = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // Step codes and timing
   localparam logic [3:0] FPA_CODE_OFF = 4'h0;
   localparam logic [3:0] FPA_CODE_MAX = 4'hd;
   localparam int FPA_CLK_MHZ       = 250;
   localparam int FPA_MS_IN_NS      = 1000000;
   localparam int FPA_CLK_PERIOD_NS = 1000 / FPA_CLK_MHZ;
   localparam int FPA_MS_CYCLES     = FPA_MS_IN_NS / FPA_CLK_PERIOD_NS;
   localparam logic [1:0] FPA_RESP_OKAY   = 2'b00;
   localparam logic [1:0] FPA_RESP_SLVERR = 2'b10;

   // Per-output request bundle from the surrounding fan logic
   typedef struct packed {
      logic [3:0] auto_code;
      logic       tach_over;
   } fpa_req_type;

   typedef enum logic [1:0] {FPA_R_IDLE, FPA_R_UP, FPA_R_DOWN} fpa_ramp_type;

endpackage
`default_nettype wire

// [fpa_arbiter.sv]
// Fan duty arbiter: merges all duty requests into one 4-bit code per output,
// then maps it to an 8-bit duty under the default or alternate table.
// Assumes zone, tach and throttle results arrive from logic on aclk;
// the regulator-hot pins are asynchronous and synchronised here.
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module fpa_arbiter #(
   parameter int MS_CYCLES = fpa_pkg::FPA_MS_CYCLES
) (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   // AXI4-Lite slave
   input  wire logic [7:0]             s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [7:0]             s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   // Thermal and fan status
   input  wire logic [3:0]             zone_boost,
   input  wire fpa_pkg::fpa_req_type   req_one,
   input  wire fpa_pkg::fpa_req_type   req_two,
   input  wire logic                   regulator_hot_one,
   input  wire logic                   regulator_hot_two,
   input  wire logic                   cpu_one_throttle,
   input  wire logic                   cpu_two_throttle,
   input  wire logic                   throttle_update,
   // Fan drive duty
   output logic [7:0]                  fan_drive_one,
   output logic [7:0]                  fan_drive_two
);

   // Elaboration check: the millisecond counter is only 18 bits wide
   if (MS_CYCLES < 1 || MS_CYCLES > 262144)
   begin : ms_range_check
      $error("MS_CYCLES must lie between 1 and 262144");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [31:0] ctrl_reg;
   logic [31:0] manual_reg;   // [0],[1] enables; [7:4],[11:8] codes
   logic [31:0] bind_reg;     // [3:0] reg-hot pairs, [7:4] throttle pairs
   logic [7:0]  ramp_ms_reg;
   logic [15:0] spin_reg;     // [3:0] code, [15:8] time in ms
   logic        aw_hold_reg;
   logic        w_hold_reg;
   logic [7:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;

   logic [7:0]  ramp_code_flat;

   // Write channels are taken independently; response after both
   assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_reg  <= 1'b0;
         w_hold_reg   <= 1'b0;
         awaddr_reg   <= 8'h00;
         wdata_reg    <= 32'h0000_0000;
         wstrb_reg    <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= fpa_pkg::FPA_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end
         if (aw_hold_reg && w_hold_reg)
         begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_reg <= fpa_pkg::FPA_SPIN_ADDR && awaddr_reg[1:0] == 2'b00)
                            ? fpa_pkg::FPA_RESP_OKAY : fpa_pkg::FPA_RESP_SLVERR;
         end
         else if (s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Register storage, byte enables honoured on the low byte lanes in use
   wire do_write = aw_hold_reg && w_hold_reg;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_reg    <= fpa_pkg::FPA_CTRL_RST;
         manual_reg  <= fpa_pkg::FPA_MANUAL_RST;
         bind_reg    <= fpa_pkg::FPA_BIND_RST;
         ramp_ms_reg <= fpa_pkg::FPA_RAMP_RST;
         spin_reg    <= fpa_pkg::FPA_SPIN_RST;
      end
      else if (do_write)
      begin
         case (awaddr_reg)
            fpa_pkg::FPA_CTRL_ADDR:   if (wstrb_reg[0]) ctrl_reg[7:0] <= wdata_reg[7:0];
            fpa_pkg::FPA_MANUAL_ADDR:
            begin
               if (wstrb_reg[0]) manual_reg[7:0]  <= wdata_reg[7:0];
               if (wstrb_reg[1]) manual_reg[15:8] <= wdata_reg[15:8];
            end
            fpa_pkg::FPA_BIND_ADDR:   if (wstrb_reg[0]) bind_reg[7:0] <= wdata_reg[7:0];
            fpa_pkg::FPA_RAMP_ADDR:   if (wstrb_reg[0]) ramp_ms_reg <= wdata_reg[7:0];
            fpa_pkg::FPA_SPIN_ADDR:
            begin
               if (wstrb_reg[0]) spin_reg[7:0]  <= wdata_reg[7:0];
               if (wstrb_reg[1]) spin_reg[15:8] <= wdata_reg[15:8];
            end
            default: ;
         endcase
      end
   end

   // Read channel: one read outstanding, answer one cycle after address
   logic [3:0] code_one;
   logic [3:0] code_two;
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= fpa_pkg::FPA_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= fpa_pkg::FPA_RESP_OKAY;
         case (s_axi_araddr)
            fpa_pkg::FPA_CTRL_ADDR:   s_axi_rdata <= {24'h0, ctrl_reg[7:0]};
            fpa_pkg::FPA_MANUAL_ADDR: s_axi_rdata <= {16'h0, manual_reg[15:0]};
            fpa_pkg::FPA_BIND_ADDR:   s_axi_rdata <= {24'h0, bind_reg[7:0]};
            fpa_pkg::FPA_RAMP_ADDR:   s_axi_rdata <= {24'h0, ramp_ms_reg};
            fpa_pkg::FPA_SPIN_ADDR:   s_axi_rdata <= {16'h0, spin_reg};
            fpa_pkg::FPA_STATUS_ADDR: s_axi_rdata <= {16'h0, ramp_code_flat, code_two, code_one};
            default:
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= fpa_pkg::FPA_RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Synchronisers for the asynchronous hot pins
   logic [1:0] hot_meta_reg;
   logic [1:0] hot_sync_reg;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         hot_meta_reg <= 2'b00;
         hot_sync_reg <= 2'b00;
      end
      else
      begin
         hot_meta_reg <= {regulator_hot_two, regulator_hot_one};
         hot_sync_reg <= hot_meta_reg;
      end
   end

   // Millisecond tick, then ramp interval tick
   logic [17:0] ms_cnt_reg;
   logic [7:0]  iv_cnt_reg;
   logic        ms_tick;
   logic        step_tick;
   assign ms_tick   = (ms_cnt_reg == 18'(MS_CYCLES - 1));
   assign step_tick = ms_tick && (iv_cnt_reg + 8'h01 >= ramp_ms_reg);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ms_cnt_reg <= 18'h0;
         iv_cnt_reg <= 8'h00;
      end
      else
      begin
         ms_cnt_reg <= ms_tick ? 18'h0 : ms_cnt_reg + 18'h1;
         if (step_tick)
            iv_cnt_reg <= 8'h00;
         else if (ms_tick)
            iv_cnt_reg <= iv_cnt_reg + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Requests per output; other_code is everything except the ramps, base_code adds them
   logic       force_full;
   logic [3:0] other_code [2];
   logic [3:0] spin_req   [2];
   logic [3:0] base_code  [2];
   logic [3:0] auto_in    [2];
   logic [3:0] ramp_req   [2];   // Max of this output's ramps
   assign auto_in[0] = req_one.auto_code;
   assign auto_in[1] = req_two.auto_code;

   // Zone boost, tach limit and force bit all pin every output to full
   assign force_full = (|zone_boost)
                     || req_one.tach_over || req_two.tach_over
                     || ctrl_reg[fpa_pkg::FPA_CTRL_FORCE_BIT];

   function automatic logic [3:0] clamp_code(input logic [3:0] c);
      clamp_code = (c > fpa_pkg::FPA_CODE_MAX) ? fpa_pkg::FPA_CODE_MAX : c;
   endfunction

   function automatic logic [3:0] max_code(input logic [3:0] a, input logic [3:0] b);
      max_code = (a > b) ? a : b;
   endfunction

   // Priority merge; manual replaces spin-up and automatic control
   always_comb
   begin
      for (int o = 0; o < 2; o++)
      begin
         other_code[o] = force_full ? fpa_pkg::FPA_CODE_MAX : fpa_pkg::FPA_CODE_OFF;
         if (manual_reg[o])
            other_code[o] = max_code(other_code[o], clamp_code(manual_reg[4*o+4 +: 4]));
         else
            other_code[o] = max_code(other_code[o],
                               max_code(spin_req[o], clamp_code(auto_in[o])));
         base_code[o] = max_code(other_code[o], ramp_req[o]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Ramps: index r = 2*kind + input; kind 0 regulator-hot, 1 throttle
   logic [3:0]   rcode_reg [8];
   logic [7:0]   ron_reg;

   // Throttle level only counts on a fresh measurement
   logic [1:0] thr_latched_reg;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         thr_latched_reg <= 2'b00;
      else if (throttle_update)
         thr_latched_reg <= {cpu_two_throttle, cpu_one_throttle};
   end

   // One ramp per output/input pair: slot = 4*output + source
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ron_reg <= 8'h00;
         for (int i = 0; i < 8; i++)
            rcode_reg[i] <= fpa_pkg::FPA_CODE_OFF;
      end
      else
      begin
         for (int i = 0; i < 8; i++)
         begin
            automatic int  o   = i / 4;
            automatic int  s   = i % 4;
            automatic logic hot = (s < 2) ? hot_sync_reg[s % 2] : thr_latched_reg[s % 2];
            if (!bind_reg[s*2 + o])
            begin
               ron_reg[i]   <= 1'b0;
               rcode_reg[i] <= fpa_pkg::FPA_CODE_OFF;
            end
            else if (!ron_reg[i])
            begin
               if (hot)
               begin
                  ron_reg[i]   <= 1'b1;
                  rcode_reg[i] <= clamp_code(other_code[o] + 4'h1);
               end
            end
            else if (hot)
            begin
               if (step_tick && rcode_reg[i] < fpa_pkg::FPA_CODE_MAX)
                  rcode_reg[i] <= rcode_reg[i] + 4'h1;
            end
            else if (rcode_reg[i] < other_code[o])
               ron_reg[i] <= 1'b0;
            else if (step_tick && rcode_reg[i] != fpa_pkg::FPA_CODE_OFF)
               rcode_reg[i] <= rcode_reg[i] - 4'h1;
         end
      end
   end

   // Largest enabled ramp per output
   always_comb
   begin
      for (int o = 0; o < 2; o++)
      begin
         ramp_req[o] = fpa_pkg::FPA_CODE_OFF;
         for (int s = 0; s < 4; s++)
            if (ron_reg[4*o+s])
               ramp_req[o] = max_code(ramp_req[o], rcode_reg[4*o+s]);
      end
      for (int i = 0; i < 8; i++)
         ramp_code_flat[i] = ron_reg[i];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Spin-up: zero to nonzero on the final code starts a timed request unless that output's manual enable is set
   logic [1:0] was_zero_reg;
   logic [7:0] spin_ms_reg [2];
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         was_zero_reg <= 2'b11;
         spin_ms_reg[0] <= 8'h00;
         spin_ms_reg[1] <= 8'h00;
      end
      else
      begin
         for (int o = 0; o < 2; o++)
         begin
            was_zero_reg[o] <= (base_code[o] == fpa_pkg::FPA_CODE_OFF);
            if (was_zero_reg[o] && base_code[o] != fpa_pkg::FPA_CODE_OFF && !manual_reg[o])
               spin_ms_reg[o] <= spin_reg[15:8];
            else if (ms_tick && spin_ms_reg[o] != 8'h00)
               spin_ms_reg[o] <= spin_ms_reg[o] - 8'h01;
         end
      end
   end
   assign spin_req[0] = (spin_ms_reg[0] != 8'h00) ? clamp_code(spin_reg[3:0]) : 4'h0;
   assign spin_req[1] = (spin_ms_reg[1] != 8'h00) ? clamp_code(spin_reg[3:0]) : 4'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Code to duty, 8-bit full scale; alternate table per output
   function automatic logic [7:0] to_duty(input logic [3:0] c, input logic alt);
      logic [7:0] d;
      d = 8'h00;
      if (c == 4'h0)
         d = 8'h00;
      else if (c >= fpa_pkg::FPA_CODE_MAX)
         d = 8'hff;
      else if (!alt)
         d = 8'(8'h40 + 8'(c - 4'h1) * 8'h10);
      else if (c <= 4'ha)
         d = 8'(16'(8'h40) + (16'(c - 4'h1) * 16'd64) / 16'd7);
      else
         d = 8'(16'h92 + (16'(c - 4'ha) * 16'd256) / 16'd7);
      to_duty = d;
   endfunction

   logic alt_one;
   logic alt_two;
   // Low frequency forces alternate; alternate may also stand alone
   assign alt_one = ctrl_reg[fpa_pkg::FPA_CTRL_LOWF0_BIT]
                    || ctrl_reg[fpa_pkg::FPA_CTRL_ALT0_BIT];
   assign alt_two = ctrl_reg[fpa_pkg::FPA_CTRL_LOWF1_BIT]
                    || ctrl_reg[fpa_pkg::FPA_CTRL_ALT1_BIT];
   assign code_one = base_code[0];
   assign code_two = base_code[1];

   // Registered duty; same table for all code sources
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fan_drive_one <= 8'h00;
         fan_drive_two <= 8'h00;
      end
      else
      begin
         fan_drive_one <= to_duty(base_code[0], alt_one);
         fan_drive_two <= to_duty(base_code[1], alt_two);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   force_full_a: assert property (@(posedge aclk) disable iff (!aresetn)
      force_full |=> fan_drive_one == 8'hff && fan_drive_two == 8'hff)
      else $error("forced duty not full");
   tach_full_a: assert property (@(posedge aclk) disable iff (!aresetn)
      req_one.tach_over |-> base_code[1] == fpa_pkg::FPA_CODE_MAX)
      else $error("tach limit did not force full");
   manual_floor_a: assert property (@(posedge aclk) disable iff (!aresetn)
      manual_reg[0] |-> base_code[0] >= clamp_code(manual_reg[7:4]))
      else $error("manual floor lost");
   alt_mid_a: assert property (@(posedge aclk) disable iff (!aresetn)
      base_code[0] == 4'h8 && alt_one |=> fan_drive_one == 8'h80)
      else $error("alternate 8h not half duty");
   ramp_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ron_reg[0] && $past(ron_reg[0]) && !step_tick
      |=> $stable(rcode_reg[0]) || !ron_reg[0])
      else $error("ramp moved off interval");
   ramp_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !ron_reg[0] && bind_reg[0] && hot_sync_reg[0] |=> ron_reg[0])
      else $error("ramp did not enable");
   // An enabled ramp stays within 0h to Dh and moves by one code at most
   ramp_cap_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ron_reg[0] && $past(ron_reg[0])
      |-> rcode_reg[0] <= fpa_pkg::FPA_CODE_MAX
          && rcode_reg[0] + 4'h1 >= $past(rcode_reg[0])
          && rcode_reg[0] <= $past(rcode_reg[0]) + 4'h1)
      else $error("ramp code out of range");
   base_max_a: assert property (@(posedge aclk) disable iff (!aresetn)
      base_code[0] >= ramp_req[0])
      else $error("ramp request ignored");
   ramp_cov_c: cover property (@(posedge aclk) ron_reg[0] && step_tick);
   spin_cov_c: cover property (@(posedge aclk) spin_ms_reg[0] != 8'h00);
   force_cov_c: cover property (@(posedge aclk) force_full);

endmodule
`default_nettype wire

// [fpa_thermal_model.sv]
// Board side model: regulator hot pins and processor throttle results.
// Assumes the bench asks for levels; throttle results move once a measurement.
`timescale 1ns/1ns
`default_nettype none
module fpa_thermal_model (
   input  wire logic       aclk,
   input  wire logic [1:0] hot_cmd,
   input  wire logic [1:0] thr_cmd,
   output var logic        regulator_hot_one = 1'h0,
   output var logic        regulator_hot_two = 1'h0,
   output var logic        cpu_one_throttle = 1'h0,
   output var logic        cpu_two_throttle = 1'h0,
   output var logic        throttle_update = 1'h0
);
   logic [3:0] tick_reg = 4'h0;
   ////////////////////////////////////////////////////////
   // Hot pins follow the bench; a throttle result only changes with a new measurement
   always_ff @(posedge aclk)
   begin
      tick_reg <= tick_reg + 4'h1;
      throttle_update <= (tick_reg == 4'hf);
      {regulator_hot_two, regulator_hot_one} <= hot_cmd;
      if (tick_reg == 4'hf)
         {cpu_two_throttle, cpu_one_throttle} <= thr_cmd;
   end
endmodule
`default_nettype wire

// [tb.sv]
// Bench for the fan duty arbiter: bus tasks, board model and duty checks.
// Assumes a 4-cycle millisecond so ramp and spin times stay short.
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic                 aclk = 1'h0, aresetn = 1'h0;
   logic [7:0]           s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0]          s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0]           s_axi_wstrb = 4'hf, zone_boost = 4'h0, a, m;
   logic                 s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic                 s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic                 s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic                 s_axi_rvalid, throttle_update;
   logic [1:0]           s_axi_bresp, s_axi_rresp, rr, hot_cmd = 2'h0, thr_cmd = 2'h0;
   fpa_pkg::fpa_req_type req_one = '0, req_two = '0;
   logic                 regulator_hot_one, regulator_hot_two;
   logic                 cpu_one_throttle, cpu_two_throttle;
   logic [7:0]           fan_drive_one, fan_drive_two, h, v, w;
   int                   n_errors = 0, n_compared = 0;
   fpa_arbiter #(.MS_CYCLES(4)) dut (.*);
   fpa_thermal_model model (.*);
   initial forever #2 aclk = ~aclk;
   ////////////////////////////////////////////////////////
   // Shared tasks; the master holds each channel until its own ready
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] dat);
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata} <= {ad, dat};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      rr = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] ad);
      @(posedge aclk);
      s_axi_araddr <= ad;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      {d, rr} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'h0;
   endtask
   // Final codes of both outputs as reported in the status word
   task automatic st(input string nm, input logic [3:0] e1, input logic [3:0] e2);
      rd(8'h14);
      chk(nm, {24'h0, e2, e1}, {24'h0, d[7:0]});
   endtask
   // Duty of output one for a control word and an automatic code
   task automatic dv(input logic [31:0] ctrl, input logic [3:0] c, output logic [7:0] o);
      wr(8'h00, ctrl);
      req_one.auto_code <= c;
      repeat (6) @(posedge aclk);
      o = fan_drive_one;
   endtask
   // Expected code with everything else idle; reserved codes clamp to full
   function automatic logic [3:0] fin(input logic men, input logic [3:0] man, au);
      logic [3:0] c;
      c = men ? man : au;
      return (c > 4'hd) ? 4'hd : c;
   endfunction
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Watchdog well beyond the few thousand cycles the run needs
   initial
   begin
      #100000;
      n_errors++;
      stop_test;
   end
   ////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      void'($urandom(1));
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      chk("fan reset", 32'h0, {24'h0, fan_drive_one});
      rd(8'h00);
      chk("ctrl reset", fpa_pkg::FPA_CTRL_RST, d);
      rd(8'h0c);
      chk("ramp reset", {24'h0, fpa_pkg::FPA_RAMP_RST}, d);
      rd(8'h1c);
      chk("unmapped read", {30'h0, fpa_pkg::FPA_RESP_SLVERR}, {d[29:0], rr});
      wr(8'h1c, 32'h5);
      chk("unmapped write", {30'h0, fpa_pkg::FPA_RESP_SLVERR}, {30'h0, rr});
      // Only the low byte lane is enabled, so the manual codes stay clear
      s_axi_wstrb <= 4'h1;
      wr(8'h04, 32'hf00);
      s_axi_wstrb <= 4'hf;
      rd(8'h04);
      chk("strobe mask", 32'h0, d);
      // Automatic requests, then manual override on output one
      for (int i = 0; i < 12; i++)
      begin
         a = 4'($urandom_range(15));
         m = 4'($urandom_range(15));
         req_one.auto_code <= 4'($urandom_range(15));
         req_two.auto_code <= a;
         if (i == 6) wr(8'h04, {24'h0, m, 4'h1});
         if (i > 5) m = fin(1'h1, d[7:4], 4'h0);
         repeat (5) @(posedge aclk);
         rd(8'h04);
         st("final codes", fin(i > 5, d[7:4], req_one.auto_code), fin(1'h0, 4'h0, a));
      end
      // Any full-speed source overrides manual and automatic requests
      for (int i = 0; i < 3; i++)
      begin
         if (i == 0) zone_boost <= 4'($urandom_range(15, 1));
         if (i == 1) {req_one.tach_over, req_two.tach_over} <= 2'($urandom_range(3, 1));
         if (i == 2) wr(8'h00, 32'h1);
         repeat (3) @(posedge aclk);
         chk("forced duty", 32'hffff, {16'h0, fan_drive_one, fan_drive_two});
         zone_boost <= 4'h0;
         {req_one.tach_over, req_two.tach_over} <= 2'h0;
         wr(8'h00, 32'h0);
      end
      wr(8'h04, 32'h0);
      // Default against alternate mapping at equal duties
      dv(32'h0, 4'h5, h);
      dv(32'h2, 4'h8, w);
      chk("alt half", {24'h0, h}, {24'h0, w});
      dv(32'h8, 4'h8, w);
      chk("lowfreq half", {24'h0, h}, {24'h0, w});
      dv(32'h2, 4'hd, w);
      chk("alt full", 32'hff, {24'h0, w});
      // Bh is 71.37 percent of full scale ff
      dv(32'h2, 4'hb, w);
      chk("alt step b", 32'hb6, {24'h0, w});
      dv(32'h0, 4'h1, v);
      dv(32'h2, 4'h1, w);
      chk("alt first", {24'h0, v}, {24'h0, w});
      wr(8'h04, 32'h81);
      dv(32'h2, 4'h0, w);
      chk("alt manual", {24'h0, h}, {24'h0, w});
      wr(8'h04, 32'h0);
      dv(32'h0, 4'h0, w);
      chk("zero duty", 32'h0, {24'h0, w});
      // Spin-up on a rise from zero
      req_two.auto_code <= 4'h2;
      wr(8'h10, 32'h1409);
      req_one.auto_code <= 4'h1;
      repeat (3) @(posedge aclk);
      st("spin active", 4'h9, 4'h2);
      repeat (120) @(posedge aclk);
      st("spin over", 4'h1, 4'h2);
      wr(8'h10, 32'h0);
      // Regulator hot ramp bound to output one only; a long interval keeps
      // a step from landing before the capture is read, then 40-cycle steps
      wr(8'h08, 32'h1);
      wr(8'h0c, 32'hff);
      a = 4'($urandom_range(12, 1));
      req_one.auto_code <= a;
      repeat (4) @(posedge aclk);
      hot_cmd <= 2'h3;
      repeat (5) @(posedge aclk);
      st("ramp capture", a + 4'h1, 4'h2);
      wr(8'h0c, 32'ha);
      repeat (700) @(posedge aclk);
      st("ramp top", 4'hd, 4'h2);
      hot_cmd <= 2'h0;
      repeat (700) @(posedge aclk);
      st("ramp down", a, 4'h2);
      chk("ramp idle", 32'h0, {24'h0, d[15:8]});
      // Both throttle inputs bound to output two, only one hot
      wr(8'h08, 32'ha0);
      thr_cmd <= 2'h2;
      repeat (700) @(posedge aclk);
      st("throttle top", a, 4'hd);
      thr_cmd <= 2'h0;
      repeat (800) @(posedge aclk);
      st("throttle down", a, 4'h2);
      stop_test;
   end
endmodule
`default_nettype wire
